// >>> hw/bls_top.sv
/*
  Byte lane steering for byte reads from 16-bit or 8-bit wide and byte
  writes to 16-bit wide external memory, one access of one strobe cycle per request.
  Assumes synchronous inputs on clk_i and a memory that drives its data
  within the strobe cycle.
*/
`timescale 1ns/1ns
`include "bls_map.svh"

// Notes on behaviour
// - Read bytes go back on the read data port and write bytes come in on the request port.
// - A byte write to 16-bit memory enables only the addressed byte lane.
// - A byte read from 16-bit memory is a full 16-bit access with the byte picked internally.
// - For 16-bit memory A1 is the lowest address line and address bit 0 steers byte, lanes and enable.
// - Bit 0 low on a 16-bit write puts the byte on the upper lanes with only the upper enable low.
// - Bit 0 high on a 16-bit write puts the byte on the lower lanes with only the lower enable low.
// - No write cycle is ever issued to 8-bit memory; such requests are refused.
// - A byte read from 8-bit memory uses A0 as lowest line and only the lower lanes.
// - During a read from 8-bit memory the upper enable is high and the lower enable low.
// - Any 16-bit access of 16-bit memory drives both enables low and uses all sixteen lanes.
module bls_top #(
  parameter int ADDR_W = bls_pkg::ADDR_W
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  input  wire logic              mem_wide16_i,
  input  wire logic              req_valid_i,
  input  wire bls_pkg::bls_req_t req_i,
  output logic                   req_ready_o,
  output logic                   rd_valid_o,
  output logic      [7:0]        rd_data_o,
  output logic                   wr_done_o,
  output logic                   err_o,
  output logic      [ADDR_W-1:0] mem_addr_o,
  output logic      [15:0]       mem_dout_o,
  output logic                   mem_doe_o,
  input  wire logic [15:0]       mem_din_i,
  output logic                   upper_byte_enable_n_o,
  output logic                   lower_byte_enable_n_o,
  output logic                   mem_rd_n_o,
  output logic                   mem_wr_n_o
);

  // ****************************************
  // Declarations
  // ****************************************
  bls_pkg::bls_state_t state;
  bls_pkg::bls_state_t next_state;
  logic                take;
  logic                refuse;
  logic                start;
  logic                cur_write;
  logic                cur_a0;
  logic                cur_wide16;
  logic [1:0]          lane_be_n;
  logic [15:0]         lane_dout;
  logic [7:0]          lane_rbyte;
  logic [ADDR_W-1:0]   next_addr;
  logic                sel_write;
  logic                sel_a0;
  logic                sel_wide16;

  // ****************************************
  // Request acceptance
  // ****************************************
  assign take   = ce_i && req_valid_i && req_ready_o;
  assign refuse = take && req_i.write && !mem_wide16_i;
  assign start  = take && !refuse;

  // ****************************************
  // Lane steering
  // ****************************************
  // Request context while idle, held context during the access
  assign sel_write  = (state == bls_pkg::BLS_IDLE) ? req_i.write    : cur_write;
  assign sel_a0     = (state == bls_pkg::BLS_IDLE) ? req_i.addr[0]  : cur_a0;
  assign sel_wide16 = (state == bls_pkg::BLS_IDLE) ? mem_wide16_i   : cur_wide16;

  bls_lane u_lane (
    .wide16_i (sel_wide16),
    .write_i  (sel_write),
    .a0_i     (sel_a0),
    .wdata_i  (req_i.wdata),
    .din_i    (mem_din_i),
    .be_n_o   (lane_be_n),
    .dout_o   (lane_dout),
    .rbyte_o  (lane_rbyte)
  );

  // ****************************************
  // External address
  // ****************************************
  always_comb begin
    next_addr = req_i.addr;
    if (mem_wide16_i) begin
      next_addr[0] = `BLS_A0_UNUSED;
    end
  end

  // ****************************************
  // State sequence
  // ****************************************
  always_comb begin
    case (state)
      bls_pkg::BLS_IDLE: begin
        next_state = start ? bls_pkg::BLS_ACCESS : bls_pkg::BLS_IDLE;
      end
      bls_pkg::BLS_ACCESS: begin
        next_state = bls_pkg::BLS_DONE;
      end
      bls_pkg::BLS_DONE: begin
        next_state = bls_pkg::BLS_IDLE;
      end
      default: begin
        next_state = bls_pkg::BLS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= bls_pkg::BLS_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // ****************************************
  // Ready to the requester
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_ready_o <= 1'b0;
    end else if (ce_i) begin
      req_ready_o <= (next_state == bls_pkg::BLS_IDLE);
    end
  end

  // ****************************************
  // Access context
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_write  <= 1'b0;
      cur_a0     <= 1'b0;
      cur_wide16 <= 1'b0;
    end else if (ce_i && start) begin
      cur_write  <= req_i.write;
      cur_a0     <= req_i.addr[0];
      cur_wide16 <= mem_wide16_i;
    end
  end

  // ****************************************
  // Address and byte enables
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_addr_o            <= '0;
      upper_byte_enable_n_o <= `BLS_STROBE_OFF;
      lower_byte_enable_n_o <= `BLS_STROBE_OFF;
    end else if (ce_i) begin
      if (start) begin
        mem_addr_o            <= next_addr;
        upper_byte_enable_n_o <= lane_be_n[1];
        lower_byte_enable_n_o <= lane_be_n[0];
      end else if (state == bls_pkg::BLS_ACCESS) begin
        upper_byte_enable_n_o <= `BLS_STROBE_OFF;
        lower_byte_enable_n_o <= `BLS_STROBE_OFF;
      end
    end
  end

  // ****************************************
  // Strobes
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_rd_n_o <= `BLS_STROBE_OFF;
      mem_wr_n_o <= `BLS_STROBE_OFF;
    end else if (ce_i) begin
      if (start) begin
        mem_rd_n_o <= req_i.write;
        mem_wr_n_o <= !req_i.write;
      end else begin
        mem_rd_n_o <= `BLS_STROBE_OFF;
        mem_wr_n_o <= `BLS_STROBE_OFF;
      end
    end
  end

  // ****************************************
  // Write data drive
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_dout_o <= `BLS_WORD_ZERO;
      mem_doe_o  <= 1'b0;
    end else if (ce_i) begin
      if (start && req_i.write) begin
        mem_dout_o <= lane_dout;
        mem_doe_o  <= 1'b1;
      end else if (state == bls_pkg::BLS_ACCESS) begin
        mem_doe_o  <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read data return
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= `BLS_BYTE_ZERO;
    end else if (ce_i) begin
      rd_valid_o <= (state == bls_pkg::BLS_ACCESS) && !cur_write;
      if (state == bls_pkg::BLS_ACCESS && !cur_write) begin
        rd_data_o <= lane_rbyte;
      end
    end
  end

  // ****************************************
  // Write completion and refusal
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_done_o <= 1'b0;
      err_o     <= 1'b0;
    end else if (ce_i) begin
      wr_done_o <= (state == bls_pkg::BLS_ACCESS) && cur_write;
      err_o     <= refuse;
    end
  end

endmodule // bls_top

// >>> hw/bls_map.svh
/*
  Constants of the byte lane steering block: lane positions, byte enable
  patterns, idle pin levels and reset values.
  Assumes inclusion by bare name, after which every name is visible.
*/
`ifndef BLS_MAP_SVH
`define BLS_MAP_SVH

// ****************************************
// Lane positions on the external data bus
// ****************************************
`define BLS_UP_MSB      15
`define BLS_UP_LSB      8
`define BLS_LO_MSB      7
`define BLS_LO_LSB      0

// ****************************************
// Byte enable patterns {upper_n, lower_n}
// ****************************************
`define BLS_BE_BOTH     2'h0
`define BLS_BE_UPPER    2'h1
`define BLS_BE_LOWER    2'h2
`define BLS_BE_NONE     2'h3

// ****************************************
// Idle levels and reset values
// ****************************************
`define BLS_BYTE_ZERO   8'h00
`define BLS_WORD_ZERO   16'h0000
`define BLS_STROBE_OFF  1'h1
`define BLS_A0_UNUSED   1'h0

`endif

// >>> hw/bls_pkg.sv
/*
  Types of the byte lane steering block: request carrier and state enum.
  Assumes the compile order header, package, modules.
*/
package bls_pkg;

  parameter int ADDR_W = 16;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } bls_req_t;

  // Gray codes along idle, access, done
  typedef enum logic [1:0] {
    BLS_IDLE   = 2'h0,
    BLS_ACCESS = 2'h1,
    BLS_DONE   = 2'h3
  } bls_state_t;

endpackage

// >>> hw/bls_lane.sv
/*
  Combinational lane steering: byte enables, write lanes and read byte
  selection from address bit 0 and the memory width.
  Assumes its outputs are registered by the instantiating module.
*/
`timescale 1ns/1ns
`include "bls_map.svh"

module bls_lane (
  input  wire logic        wide16_i,
  input  wire logic        write_i,
  input  wire logic        a0_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [15:0] din_i,
  output logic      [1:0]  be_n_o,
  output logic      [15:0] dout_o,
  output logic      [7:0]  rbyte_o
);

  // ****************************************
  // Byte enables
  // ****************************************
  always_comb begin
    if (!wide16_i) begin
      be_n_o = `BLS_BE_LOWER;
    end else if (!write_i) begin
      be_n_o = `BLS_BE_BOTH;
    end else if (a0_i) begin
      be_n_o = `BLS_BE_LOWER;
    end else begin
      be_n_o = `BLS_BE_UPPER;
    end
  end

  // ****************************************
  // Write lanes
  // ****************************************
  always_comb begin
    dout_o = `BLS_WORD_ZERO;
    if (a0_i) begin
      dout_o[`BLS_LO_MSB:`BLS_LO_LSB] = wdata_i;
    end else begin
      dout_o[`BLS_UP_MSB:`BLS_UP_LSB] = wdata_i;
    end
  end

  // ****************************************
  // Read byte selection
  // ****************************************
  always_comb begin
    if (!wide16_i || a0_i) begin
      rbyte_o = din_i[`BLS_LO_MSB:`BLS_LO_LSB];
    end else begin
      rbyte_o = din_i[`BLS_UP_MSB:`BLS_UP_LSB];
    end
  end

endmodule // bls_lane

// >>> sim/bls_monitor.sv
/*
  Port checker of bls_top, bound to every instance.
  Assumes ce_i stays high while requests run.
*/
`timescale 1ns/1ns
module bls_monitor #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              ce_i,
  input wire logic              mem_wide16_i,
  input wire logic              req_valid_i,
  input wire bls_pkg::bls_req_t req_i,
  input wire logic              req_ready_o,
  input wire logic              rd_valid_o,
  input wire logic [7:0]        rd_data_o,
  input wire logic              err_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [15:0]       mem_dout_o,
  input wire logic              mem_doe_o,
  input wire logic [15:0]       mem_din_i,
  input wire logic              upper_byte_enable_n_o,
  input wire logic              lower_byte_enable_n_o,
  input wire logic              mem_rd_n_o,
  input wire logic              mem_wr_n_o
);
  logic tk;
  logic ub;
  logic lb;
  assign tk = ce_i && req_valid_i && req_ready_o;
  assign ub = upper_byte_enable_n_o;
  assign lb = lower_byte_enable_n_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_wr_up;
    tk && req_i.write && mem_wide16_i && !req_i.addr[0] |=>
      !ub && lb && !mem_wr_n_o && mem_dout_o[15:8] == $past(req_i.wdata);
  endproperty
  a_wr_up: assert property (p_wr_up) else $error("upper byte write wrong");
  property p_wr_lo;
    tk && req_i.write && mem_wide16_i && req_i.addr[0] |=>
      ub && !lb && !mem_wr_n_o && mem_dout_o[7:0] == $past(req_i.wdata);
  endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("lower byte write wrong");
  property p_rd16;
    tk && !req_i.write && mem_wide16_i |=> !ub && !lb && !mem_rd_n_o && !mem_addr_o[0];
  endproperty
  a_rd16: assert property (p_rd16) else $error("wide read pins wrong");
  property p_rd8;
    tk && !req_i.write && !mem_wide16_i |=> ub && !lb && mem_addr_o == $past(req_i.addr);
  endproperty
  a_rd8: assert property (p_rd8) else $error("narrow read pins wrong");
  property p_no8wr;
    tk && req_i.write && !mem_wide16_i |=> err_o && mem_wr_n_o ##1 mem_wr_n_o;
  endproperty
  a_no8wr: assert property (p_no8wr) else $error("write to narrow memory");
  property p_sel;
    tk && !req_i.write && mem_wide16_i |=> ##1 rd_valid_o &&
      rd_data_o == ($past(req_i.addr[0], 2) ? $past(mem_din_i[7:0]) : $past(mem_din_i[15:8]));
  endproperty
  a_sel: assert property (p_sel) else $error("read byte pick wrong");
  property p_rd8d;
    tk && !req_i.write && !mem_wide16_i |=> ##1 rd_valid_o && rd_data_o == $past(mem_din_i[7:0]);
  endproperty
  a_rd8d: assert property (p_rd8d) else $error("narrow read data wrong");
  property p_one;
    !mem_wr_n_o |-> (ub ^ lb) && mem_doe_o && !mem_addr_o[0];
  endproperty
  a_one: assert property (p_one) else $error("write enables wrong");
  c_wr: cover property (tk && req_i.write && mem_wide16_i);
  c_rd: cover property (tk && !req_i.write && !mem_wide16_i);
  c_er: cover property (err_o);
endmodule // bls_monitor

bind bls_top bls_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .mem_wide16_i(mem_wide16_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .err_o(err_o),
  .mem_addr_o(mem_addr_o), .mem_dout_o(mem_dout_o), .mem_doe_o(mem_doe_o),
  .mem_din_i(mem_din_i), .upper_byte_enable_n_o(upper_byte_enable_n_o),
  .lower_byte_enable_n_o(lower_byte_enable_n_o), .mem_rd_n_o(mem_rd_n_o),
  .mem_wr_n_o(mem_wr_n_o));

// >>> sim/bls_mem.sv
/*
  Behavioural external memory, 16 words, usable as 16-bit or 8-bit part.
  Assumes one-cycle strobes; released lanes show inverted last data.
*/
`timescale 1ns/1ns
module bls_mem (
  input  wire logic        clk_i,
  input  wire logic        w16_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        ube_n_i,
  input  wire logic        lbe_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] dout_i,
  output logic      [15:0] din_o
);
  logic [15:0] m [16];
  logic [15:0] rdv;
  logic [15:0] last;
  logic [3:0]  ix;
  initial begin
    last = 16'h0000;
    for (int i = 0; i < 16; i++) m[i] = {4'hE, i[3:0], 4'h1, i[3:0]};
  end
  assign ix    = w16_i ? addr_i[4:1] : addr_i[3:0];
  assign rdv   = w16_i ? m[ix] : {~last[15:8], m[ix][7:0]};
  assign din_o = rd_n_i ? ~last : rdv;
  always @(posedge clk_i) begin
    if (!rd_n_i) last <= rdv;
    if (!wr_n_i && !ube_n_i) m[ix][15:8] <= dout_i[15:8];
    if (!wr_n_i && !lbe_n_i) m[ix][7:0] <= dout_i[7:0];
  end
endmodule // bls_mem

// >>> sim/tb.sv
/*
  Self-checking bench of bls_top with memory model bls_mem.
  Assumes the design package and header are compiled first.
*/
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic w16; logic wr; logic [15:0] a; logic [7:0] wd; logic [7:0] ex;} bls_row_t;
  logic              clk_i, rstn_i, ce_i, mem_wide16_i, req_valid_i;
  bls_pkg::bls_req_t req_i;
  logic              rdy, rv, wdn, err, doe, ube, lbe, rd_n, wr_n;
  logic [7:0]        rd;
  logic [15:0]       ad, dout, din;
  int                err_total, num_checks;
  bls_row_t          rows [12];
  bls_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .mem_wide16_i(mem_wide16_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(rdy), .rd_valid_o(rv),
    .rd_data_o(rd), .wr_done_o(wdn), .err_o(err), .mem_addr_o(ad), .mem_dout_o(dout),
    .mem_doe_o(doe), .mem_din_i(din), .upper_byte_enable_n_o(ube),
    .lower_byte_enable_n_o(lbe), .mem_rd_n_o(rd_n), .mem_wr_n_o(wr_n));
  bls_mem u_mem (.clk_i(clk_i), .w16_i(mem_wide16_i), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .ube_n_i(ube), .lbe_n_i(lbe), .addr_i(ad), .dout_i(dout), .din_o(din));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rchk();
    #1 chk("reset", {rdy, ube, lbe, rd_n, wr_n, doe, rv, wdn, err, rd}, 17'h0F000);
    chk("raddr", ad | dout, 16'h0000);
  endtask
  task automatic acc(bls_row_t r);
    logic        rf;
    logic [1:0]  eb;
    int          n;
    rf = r.wr & !r.w16;
    eb = !r.w16 ? (r.wr ? 2'h3 : 2'h2) : (!r.wr ? 2'h0 : (r.a[0] ? 2'h2 : 2'h1));
    n = 0;
    @(negedge clk_i);
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (rdy !== 1'b1) begin
      err_total++;
      return;
    end
    mem_wide16_i = r.w16;
    req_i = '{r.wr, r.a, r.wd};
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    chk("pins", {rdy, ube, lbe, rd_n, wr_n, doe, err}, {rf, eb, r.wr | rf, !r.wr | rf, r.wr & !rf, rf});
    if (!rf) chk("addr", ad, r.w16 ? {r.a[15:1], 1'b0} : r.a);
    if (r.wr & !rf) chk("dout", dout, r.a[0] ? {8'h00, r.wd} : {r.wd, 8'h00});
    @(negedge clk_i);
    chk("done", {rv, wdn, err, rdy, ube, lbe, rd_n, wr_n, doe}, {!r.wr, r.wr & !rf, 1'b0, rf, 5'h1E});
    if (!r.wr) chk("rdata", rd, r.ex);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    err_total = 0;
    num_checks = 0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    mem_wide16_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    rows = '{'{1, 1, 16'h0010, 8'h5A, 8'h00}, '{1, 1, 16'h0011, 8'h3C, 8'h00},
             '{1, 0, 16'h0010, 8'h00, 8'h5A}, '{1, 0, 16'h0011, 8'h00, 8'h3C},
             '{1, 1, 16'h0013, 8'h77, 8'h00}, '{1, 0, 16'h0012, 8'h00, 8'hE9},
             '{1, 0, 16'h0013, 8'h00, 8'h77}, '{0, 0, 16'h0008, 8'h00, 8'h3C},
             '{0, 0, 16'h0007, 8'h00, 8'h17}, '{0, 1, 16'h0004, 8'h99, 8'h00},
             '{0, 1, 16'h0005, 8'h99, 8'h00}, '{0, 0, 16'h0004, 8'h00, 8'h14}};
    repeat (2) @(negedge clk_i);
    rchk();
    rstn_i = 1'b1;
    foreach (rows[i]) acc(rows[i]);
    // ****************
    // Reset mid access
    // ****************
    @(negedge clk_i);
    req_i = '{1'b0, 16'h0010, 8'h00};
    mem_wide16_i = 1'b1;
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    rstn_i = 1'b0;
    rchk();
    @(negedge clk_i);
    rstn_i = 1'b1;
    acc(rows[2]);
    // ****************
    // Clock enable low
    // ****************
    @(negedge clk_i);
    ce_i = 1'b0;
    req_i = '{1'b0, 16'h0011, 8'h00};
    req_valid_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("freeze", {rdy, rd_n, rv}, 3'h6);
    ce_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    chk("thaw", {rdy, ube, lbe, rd_n, ad[0]}, 5'h00);
    @(negedge clk_i);
    chk("thaw_data", {rv, rd}, {1'b1, 8'h3C});
    end_sim();
  end
endmodule // tb
